// ---- hdl/interrupt_global_control.v ----
// interrupt controller global control register with ahb-lite slave
// Functional notes
// [RULE_01] Bit 12 set selects multi-vectored mode, clear selects single-vectored mode.
// [RULE_02] Threshold codes 2 to 7 in bits 10..8 let any priority at or below the code start the proximity timer.
// [RULE_03] Threshold code 1 lets only priority 1 start the proximity timer.
// [RULE_04] Threshold code 0 keeps the proximity timer disabled for every priority.
// [RULE_05] Edge bits 0..4 pick rising (1) or falling (0) detection on external inputs 0..4.
// [RULE_06] Bits 31..13, 11 and 7..5 of the control register read as zero.
// [RULE_07] All control bits clear at reset and writes to unimplemented bits are ignored.
`timescale 1ns/100ps
`include "irq_global_map.vh"
module interrupt_global_control (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [4:0] ext_irq_pin,
   input wire irq_request,
   input wire [2:0] irq_priority,
   output reg vector_mode_select,
   output reg [4:0] ext_irq_event,
   output reg proximity_start,
   output reg irq_out
);
   // ****************************************
   // functions
   // ****************************************
   // proximity start decision for a threshold and priority
   function prox_hit;
      input [2:0] thr;
      input [2:0] pri;
      begin
         if (thr == `TPC_OFF)
            prox_hit = 1'b0; // [RULE_04]
         else if (thr == `TPC_ONLY_ONE)
            prox_hit = (pri == 3'h1); // [RULE_03]
         else
            prox_hit = (pri <= thr); // [RULE_02]
      end
   endfunction
   // write strobe for one register offset
   function wr_hit;
      input pend;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         wr_hit = pend & (addr == ofs);
      end
   endfunction
   // ****************************************
   // registers
   // ****************************************
   reg [31:0] ctrl_reg;
   reg [`STAT_BITS-1:0] status_reg;
   reg [`STAT_BITS-1:0] enable_reg;
   reg wr_pend_reg;
   reg [7:0] addr_reg;
   reg [4:0] pin_s1_reg;
   reg [4:0] pin_s2_reg;
   reg [`STAT_BITS-1:0] clear_now;
   reg [31:0] rd_next;
   reg [31:0] ctrl_next;
   reg [`STAT_BITS-1:0] enable_next;
   reg ctrl_we;
   reg enable_we;
   reg clear_we;
   wire irq_next;
   wire [4:0] edge_pulse;
   wire [`STAT_BITS-1:0] status_next;
   wire [`STAT_BITS-1:0] event_now;
   wire addr_phase;
   wire prox_now;
   assign addr_phase = hsel & hready & htrans[1];
   assign prox_now = irq_request & prox_hit(ctrl_reg[`TPC_HI:`TPC_LO], irq_priority);
   assign event_now = {prox_now, edge_pulse};
   // ****************************************
   // edge detectors
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_EXT; gi = gi + 1) begin : g_edge
         edge_detect u_edge (
            .hclk(hclk),
            .hresetn(hresetn),
            .pin(ext_irq_pin[gi]),
            .rising_sel(ctrl_reg[`EDGE_LO + gi]),
            .edge_pulse(edge_pulse[gi])
         ); // [RULE_05]
      end
   endgenerate
   // ****************************************
   // bus slave
   // ****************************************
   always @* begin
      ctrl_we = wr_hit(wr_pend_reg, addr_reg, `OFS_GLOBAL_CONTROL);
      enable_we = wr_hit(wr_pend_reg, addr_reg, `OFS_IRQ_ENABLE);
      clear_we = wr_hit(wr_pend_reg, addr_reg, `OFS_IRQ_CLEAR);
   end
   // ****************************************
   // interrupt clear
   // ****************************************
   always @* begin
      clear_now = {`STAT_BITS{1'b0}};
      if (clear_we) begin
         clear_now = hwdata[`STAT_BITS-1:0];
      end
   end
   // ****************************************
   // next register values
   // ****************************************
   always @* begin
      ctrl_next = ctrl_reg;
      if (ctrl_we) begin
         ctrl_next = hwdata & `CTRL_WRITE_MASK; // [RULE_07]
      end
   end
   always @* begin
      enable_next = enable_reg;
      if (enable_we) begin
         enable_next = hwdata[`STAT_BITS-1:0];
      end
   end
   // ****************************************
   // status bits
   // ****************************************
   genvar si;
   generate
      for (si = 0; si < `STAT_BITS; si = si + 1) begin : g_status
         // set wins over clear
         assign status_next[si] = event_now[si] | (status_reg[si] & ~clear_now[si]);
      end
   endgenerate
   assign irq_next = |(status_next & enable_next);
   // ****************************************
   // read data, forwarded from a write in its data phase
   // ****************************************
   always @* begin
      rd_next = 32'h00000000;
      case (haddr[7:0])
         `OFS_GLOBAL_CONTROL: rd_next = ctrl_next & `CTRL_WRITE_MASK; // [RULE_06]
         `OFS_IRQ_STATUS: rd_next = {{(32-`STAT_BITS){1'b0}}, status_next};
         `OFS_IRQ_ENABLE: rd_next = {{(32-`STAT_BITS){1'b0}}, enable_next};
         `OFS_EXT_LEVEL: rd_next = {{(32-`NUM_EXT){1'b0}}, pin_s2_reg};
         default: rd_next = 32'h00000000;
      endcase
   end
   // ****************************************
   // level synchroniser
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_reg <= 5'h00;
         pin_s2_reg <= 5'h00;
      end else begin
         pin_s1_reg <= ext_irq_pin;
         pin_s2_reg <= pin_s1_reg;
      end
   end
   // ****************************************
   // address phase capture
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_phase & hwrite;
         if (addr_phase) begin
            addr_reg <= haddr[7:0];
         end
      end
   end
   // ****************************************
   // control, enable and status registers
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `CTRL_RESET; // [RULE_07]
         enable_reg <= {`STAT_BITS{1'b0}};
         status_reg <= {`STAT_BITS{1'b0}};
      end else begin
         ctrl_reg <= ctrl_next;
         enable_reg <= enable_next;
         status_reg <= status_next;
      end
   end
   // ****************************************
   // bus response
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_phase && !hwrite) begin
            hrdata <= rd_next;
         end
      end
   end
   // ****************************************
   // outputs
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vector_mode_select <= 1'b0;
         ext_irq_event <= 5'h00;
         proximity_start <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         vector_mode_select <= ctrl_reg[`BIT_VECTOR_MODE]; // [RULE_01]
         ext_irq_event <= edge_pulse;
         proximity_start <= prox_now; // [RULE_02]
         irq_out <= irq_next;
      end
   end
endmodule // interrupt_global_control

// ---- hdl/irq_global_map.vh ----
// register offsets, fields and reset values of the global control block
`ifndef IRQ_GLOBAL_MAP_VH
`define IRQ_GLOBAL_MAP_VH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_GLOBAL_CONTROL 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_CLEAR 8'h08
`define OFS_IRQ_ENABLE 8'h0c
`define OFS_EXT_LEVEL 8'h10
// ****************************************
// control register fields
// ****************************************
`define BIT_VECTOR_MODE 12
`define TPC_HI 10
`define TPC_LO 8
`define EDGE_HI 4
`define EDGE_LO 0
`define CTRL_WRITE_MASK 32'h0000171f
`define CTRL_RESET 32'h00000000
// ****************************************
// status layout: bits 4..0 edge events, bit 5 proximity start
// ****************************************
`define STAT_BITS 6
`define STAT_PROX 5
`define NUM_EXT 5
`define TPC_OFF 3'h0
`define TPC_ONLY_ONE 3'h1
`endif

// ---- hdl/edge_detect.v ----
// synchroniser and polarity-selected edge detector for one external input
`timescale 1ns/100ps
module edge_detect (
   input wire hclk,
   input wire hresetn,
   input wire pin,
   input wire rising_sel,
   output reg edge_pulse
);
   reg sync1_reg;
   reg sync2_reg;
   reg prev_reg;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
         edge_pulse <= 1'b0;
      end else begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
         // rising when selected, falling otherwise
         edge_pulse <= rising_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg); // [RULE_05]
      end
   end
endmodule // edge_detect

// ---- test/irq_ctrl_sva.sv ----
// checker for the interrupt global control block
`timescale 1ns/100ps
module irq_ctrl_sva (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire hwrite,
   input wire hready,
   input wire irq_request,
   input wire vector_mode_select,
   input wire proximity_start,
   input wire [1:0] htrans,
   input wire [2:0] irq_priority,
   input wire [4:0] ext_irq_pin,
   input wire [4:0] ext_irq_event,
   input wire [31:0] haddr,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   reg wp;
   reg [31:0] cr;
   wire rd = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h00;
   wire [2:0] t = cr[10:8];
   wire q1 = irq_request && irq_priority == 3'h1;
   wire qn = irq_request && irq_priority <= t;
   always @(posedge hclk or negedge hresetn)
      if (!hresetn) begin
         wp <= 1'b0;
         cr <= 32'h00000000;
      end else begin
         wp <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
         if (wp) cr <= hwdata & 32'h0000171f;
      end
   a_mode_bit: assert property (vector_mode_select == $past(cr[12]))
      else $error("mode bit");
   a_prox_range: assert property (t > 3'h1 |=> proximity_start == $past(qn))
      else $error("prox range");
   a_prox_one: assert property (t == 3'h1 |=> proximity_start == $past(q1))
      else $error("prox one");
   a_prox_off: assert property (t == 3'h0 |=> !proximity_start)
      else $error("prox off");
   a_edge_pick: assert property (ext_irq_event == (($past(ext_irq_pin, 4) ^
      $past(ext_irq_pin, 5)) & ~($past(ext_irq_pin, 4) ^ $past(cr[4:0], 2))))
      else $error("edge");
   a_rsvd_zero: assert property (rd |=> (hrdata & ~32'h0000171f) == 32'h0)
      else $error("reserved bits");
   a_read_back: assert property (rd |=> hrdata == cr)
      else $error("read back");
   c_mode: cover property (vector_mode_select);
   c_prox: cover property (proximity_start);
   c_edge: cover property (|ext_irq_event);
endmodule // irq_ctrl_sva
bind interrupt_global_control irq_ctrl_sva u_sva (.*);

// ---- test/core_model.sv ----
// processor core model raising prioritised requests
`timescale 1ns/100ps
module core_model (
   input wire hclk,
   output logic irq_request = 1'b0,
   output logic [2:0] irq_priority = 3'h0
);
   task automatic req(input logic [2:0] p);
      @(posedge hclk);
      irq_request <= 1'b1;
      irq_priority <= p;
      repeat (2) @(posedge hclk);
   endtask
   task automatic drop;
      @(posedge hclk);
      irq_request <= 1'b0;
      irq_priority <= ~irq_priority;
   endtask
endmodule // core_model

// ---- test/testbench.sv ----
// self-checking bench for the interrupt global control block
`timescale 1ns/100ps
module testbench;
   logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [4:0] ext_irq_pin = 5'h00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata;
   wire [31:0] hrdata;
   wire hreadyout, hresp, irq_request, proximity_start, irq_out, vector_mode_select;
   wire [2:0] irq_priority;
   wire [4:0] ext_irq_event;
   int err_count = 0, samples_checked = 0, t, p, j;
   always #20 hclk = ~hclk;
   interrupt_global_control u_interrupt_global_control (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(1'b1),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(3'h2),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .ext_irq_pin(ext_irq_pin),
      .irq_request(irq_request),
      .irq_priority(irq_priority),
      .vector_mode_select(vector_mode_select),
      .ext_irq_event(ext_irq_event),
      .proximity_start(proximity_start),
      .irq_out(irq_out)
   );
   core_model u_core (
      .hclk(hclk),
      .irq_request(irq_request),
      .irq_priority(irq_priority)
   );
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic close_out;
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      close_out;
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h0, rdata);
      chk("hresp", 32'h0, hresp);
      xfer(1'b1, 8'h00, 32'hffffffff);
      xfer(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h0000171f, rdata);
      chk("mode", 32'h1, vector_mode_select);
      xfer(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rdata);
      xfer(1'b0, 8'h08, 32'h0);
      chk("clear read", 32'h0, rdata);
      for (t = 0; t < 8; t++) begin
         xfer(1'b1, 8'h00, t << 8);
         for (p = 0; p < 8; p++) begin
            u_core.req(p[2:0]);
            #1;
            chk("prox", t == 1 ? p == 1 : t > 1 && p <= t, proximity_start);
            u_core.drop;
         end
      end
      chk("mode", 32'h0, vector_mode_select);
      xfer(1'b1, 8'h0c, 32'h1f);
      xfer(1'b0, 8'h0c, 32'h0);
      chk("enable", 32'h0000001f, rdata);
      for (j = 0; j < 4; j++) begin
         xfer(1'b1, 8'h00, j < 2 ? 32'h1f : 32'h0);
         xfer(1'b1, 8'h08, 32'h3f);
         ext_irq_pin <= ~ext_irq_pin;
         repeat (6) @(posedge hclk);
         xfer(1'b0, 8'h04, 32'h0);
         chk("status", j == 0 || j == 3 ? 32'h1f : 32'h0, rdata);
         chk("irq", j == 0 || j == 3, irq_out);
         xfer(1'b0, 8'h10, 32'h0);
         chk("level", j == 0 || j == 2 ? 32'h1f : 32'h0, rdata);
      end
      xfer(1'b1, 8'h0c, 32'h0);
      xfer(1'b0, 8'h0c, 32'h0);
      chk("enable", 32'h0, rdata);
      chk("masked", 32'h0, irq_out);
      close_out;
   end
endmodule // testbench
